// >>> design/mpl_pkg.sv
package mpl_pkg;
    // clock and link timing
    localparam int CLK_HZ = 40_000_000;
    localparam int EE_WRITE_DELAY_MS = 20; // eeprom_write_delay
    localparam int ACCESS_TIMEOUT_MS = 8; // access_code_timeout
    localparam int OUTPUT_REENABLE_US = 125; // output_reenable_delay
    localparam int EE_WRITE_CYC = EE_WRITE_DELAY_MS * (CLK_HZ / 1000);
    localparam int ACCESS_TIMEOUT_CYC = ACCESS_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int OUTPUT_REENABLE_CYC = OUTPUT_REENABLE_US * (CLK_HZ / 1_000_000);
    // counter width covers one slowest bit_period doubled and every delay
    localparam int CNT_W = 20;
    localparam int SYNC_W = 2;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 30;
    localparam int PAYLOAD_W = 24;
    localparam int ECC_W = 6;
    localparam int CRC_W = 3;
    localparam int RD_LEN = 1 + ADDR_W + CRC_W;
    localparam int WR_LEN = 1 + ADDR_W + DATA_W + CRC_W;
    localparam int ACK_LEN = SYNC_W + DATA_W;
    localparam int SPACE_BIT = ADDR_W - 1;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic SPACE_EEPROM = 1'b0;
    localparam logic [ADDR_W-1:0] ACCESS_ADDR = 6'h24;
    localparam logic [DATA_W-1:0] ACCESS_CODE = 30'h2C41_3737;
    localparam logic [CRC_W-1:0] CRC_POLY = 3'h3;
    localparam logic [1:0] ECC_PASS = 2'h0;
    localparam logic [1:0] ECC_FAIL = 2'h2;
    localparam logic [3:0] ACK_FILL = 4'h0;

    // one serial step of the frame check, msb first
    function automatic logic [CRC_W-1:0] mpl_crc_step(input logic [CRC_W-1:0] crc,
                                                      input logic din);
        logic fb;
        fb = crc[CRC_W-1] ^ din;
        return {crc[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    endfunction

    // hamming check bits plus overall parity over the payload
    function automatic logic [ECC_W-1:0] mpl_ecc_bits(input logic [PAYLOAD_W-1:0] d);
        logic [ECC_W-1:0] c;
        c = '0;
        for (int j = 0; j < PAYLOAD_W; j++)
        begin
            for (int i = 0; i < ECC_W - 1; i++)
            begin
                if (((j + 1) >> i) % 2 == 1)
                    c[i] = c[i] ^ d[j];
            end
        end
        c[ECC_W-1] = ^d;
        return c;
    endfunction
endpackage

// >>> design/mpl_man_rx.sv
`timescale 1ns/1ps
`default_nettype none
module mpl_man_rx
    import mpl_pkg::*;
(
    input wire logic clk_i, // 40 MHz clock
    input wire logic srst_i, // synchronous reset
    input wire logic en_i, // receive window open
    input wire logic line_i, // filtered data pin level
    output logic bit_vld_o, // one-cycle strobe per decoded bit
    output logic bit_o, // decoded bit value
    output logic err_o, // missing mid-bit edge
    output logic [CNT_W-1:0] period_o // measured bit_period in cycles
);
    typedef enum logic [1:0] {RX_FIRST = 2'b00, RX_MEASURE = 2'b01, RX_RUN = 2'b10} mpl_rx_e;

    mpl_rx_e st_ff;
    logic line_d_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic rise;
    logic fall;

    assign rise = line_i & ~line_d_ff;
    assign fall = ~line_i & line_d_ff;

    // previous line level for edge detection
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            line_d_ff <= 1'b0;
        else
            line_d_ff <= line_i;
    end

    // sync field sets the bit time, later edges inside 3/4 bit are boundaries
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !en_i)
        begin
            st_ff <= RX_FIRST;
            cnt_ff <= '0;
            period_o <= '0;
            bit_vld_o <= 1'b0;
            bit_o <= 1'b0;
            err_o <= 1'b0;
        end
        else
        begin
            bit_vld_o <= 1'b0;
            err_o <= 1'b0;
            if (cnt_ff != '1)
                cnt_ff <= cnt_ff + 1'b1;
            unique case (st_ff)
                RX_FIRST:
                begin
                    if (rise) // RULE13
                    begin
                        cnt_ff <= '0;
                        st_ff <= RX_MEASURE;
                    end
                end
                RX_MEASURE:
                begin
                    if (rise) // RULE24
                    begin
                        period_o <= cnt_ff;
                        cnt_ff <= '0;
                        st_ff <= RX_RUN;
                    end
                end
                RX_RUN:
                begin
                    if ((rise || fall) && cnt_ff >= period_o - (period_o >> 2)) // RULE19
                    begin
                        bit_vld_o <= 1'b1;
                        bit_o <= fall; // RULE5
                        cnt_ff <= '0;
                    end
                    else if (cnt_ff >= {period_o[CNT_W-2:0], 1'b0})
                    begin
                        err_o <= 1'b1;
                        st_ff <= RX_FIRST;
                    end
                end
                default: st_ff <= RX_FIRST;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> design/mpl_man_tx.sv
`timescale 1ns/1ps
`default_nettype none
module mpl_man_tx
    import mpl_pkg::*;
(
    input wire logic clk_i, // 40 MHz clock
    input wire logic srst_i, // synchronous reset
    input wire logic start_i, // load word and start sending
    input wire logic [ACK_LEN-1:0] word_i, // sync plus data, msb first
    input wire logic [CNT_W-1:0] half_i, // half bit time in cycles
    output logic line_o, // coded line level
    output logic done_o // one-cycle strobe after last bit
);
    logic [ACK_LEN-1:0] sr_ff;
    logic [5:0] idx_ff;
    logic phase_ff;
    logic busy_ff;
    logic [CNT_W-1:0] cnt_ff;

    // first half carries the bit, second half its inverse
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sr_ff <= '0;
            idx_ff <= '0;
            phase_ff <= 1'b0;
            busy_ff <= 1'b0;
            cnt_ff <= '0;
            line_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i && !busy_ff)
            begin
                sr_ff <= word_i;
                idx_ff <= '0;
                phase_ff <= 1'b0;
                busy_ff <= 1'b1;
                cnt_ff <= '0;
                line_o <= word_i[ACK_LEN-1]; // RULE6
            end
            else if (busy_ff)
            begin
                cnt_ff <= cnt_ff + 1'b1;
                if (cnt_ff == half_i - 1'b1)
                begin
                    cnt_ff <= '0;
                    if (!phase_ff)
                    begin
                        phase_ff <= 1'b1;
                        line_o <= ~sr_ff[ACK_LEN-1]; // RULE5
                    end
                    else
                    begin
                        phase_ff <= 1'b0;
                        sr_ff <= {sr_ff[ACK_LEN-2:0], 1'b0};
                        if (idx_ff == 6'(ACK_LEN - 1))
                        begin
                            busy_ff <= 1'b0;
                            done_o <= 1'b1;
                            line_o <= 1'b0;
                        end
                        else
                        begin
                            idx_ff <= idx_ff + 1'b1;
                            line_o <= sr_ff[ACK_LEN-2];
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> design/mpl_link_top.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] never starts a transfer on its own
// [RULE2] write frames get no acknowledge
// [RULE3] valid read returns addressed word
// [RULE4] controller waits until acknowledge ends
// [RULE5] zero rising mid-bit, one falling
// [RULE6] address and data sent msb first
// [RULE7] four commands, only read acknowledge out
// [RULE8] program enable releases pin as input
// [RULE9] controller pulls pin low after enable
// [RULE10] enable removed: output back after delay
// [RULE11] eeprom write delay, then high-to-low edge
// [RULE12] one frame per program enable pulse
// [RULE13] frame opens with two zero bits
// [RULE14] direction bit: zero write, one read
// [RULE15] six bit address follows direction
// [RULE16] write payload bits 23:0 only
// [RULE17] read word: fill, ecc code, data
// [RULE18] three bit crc closes each command
// [RULE19] bit rate between min and max
// [RULE20] locked until access code in time
// [RULE21] top address bit picks space
// [RULE22] device computes six ecc bits
// [RULE23] bad crc frame is dropped silently
// [RULE24] bit time learned from sync edges
module mpl_link_top
    import mpl_pkg::*;
#(
    parameter int EE_WRITE_CYC_P = EE_WRITE_CYC, // eeprom_write_delay in cycles
    parameter int ACCESS_TIMEOUT_CYC_P = ACCESS_TIMEOUT_CYC, // access_code_timeout
    parameter int REENABLE_CYC_P = OUTPUT_REENABLE_CYC // output_reenable_delay
)
(
    input wire logic clk_i, // 40 MHz clock
    input wire logic srst_i, // synchronous reset, power-on
    input wire logic prog_en_i, // supply at program_enable_high_level
    input wire logic pin_i, // sensor_output_data_pin as read
    output logic pin_o, // sensor_output_data_pin drive level
    output logic pin_oe_o, // high while driving the pin
    output logic sense_en_o, // analog output path enabled
    output logic unlocked_o, // access code accepted
    output logic mem_wr_o, // one-cycle write strobe
    output logic mem_rd_o, // one-cycle read strobe
    output logic mem_vol_o, // 1 volatile registers, 0 eeprom
    output logic [ADDR_W-1:0] mem_addr_o, // word address
    output logic [DATA_W-1:0] mem_wdata_o, // ecc bits plus payload
    input wire logic [DATA_W-1:0] mem_rdata_i // stored word, valid while read strobe high
);
    typedef enum logic [2:0]
    {
        ST_NORMAL = 3'b000,
        ST_RX = 3'b001,
        ST_EXEC = 3'b010,
        ST_RDWAIT = 3'b011,
        ST_TX = 3'b100,
        ST_EEWAIT = 3'b101,
        ST_HOLD = 3'b110
    } mpl_state_e;

    mpl_state_e state_ff;
    logic [2:0] prog_s_ff;
    logic [2:0] pin_s_ff;
    logic prog_q_ff;
    logic pin_q_ff;
    logic [WR_LEN-1:0] sr_ff;
    logic [5:0] nbit_ff;
    logic [CRC_W-1:0] crc_ff;
    logic [CNT_W-1:0] tmr_ff;
    logic [CNT_W-1:0] acc_cnt_ff;
    logic acc_expired_ff;
    logic [CNT_W-1:0] re_cnt_ff;
    logic tx_start_ff;
    logic [ACK_LEN-1:0] ack_word_ff;
    logic [CNT_W-1:0] half_ff;
    logic rx_vld;
    logic rx_bit;
    logic rx_err;
    logic [CNT_W-1:0] rx_period;
    logic tx_line;
    logic tx_done;
    logic is_write;
    logic frame_full;
    logic crc_ok;
    logic [ADDR_W-1:0] f_addr;
    logic [DATA_W-1:0] f_data;
    logic [1:0] ecc_code;

    // three-stage filters, a change counts once the last two agree
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            prog_s_ff <= '0;
            pin_s_ff <= '0;
            prog_q_ff <= 1'b0;
            pin_q_ff <= 1'b0;
        end
        else
        begin
            prog_s_ff <= {prog_s_ff[1:0], prog_en_i};
            pin_s_ff <= {pin_s_ff[1:0], pin_i};
            if (prog_s_ff[1] == prog_s_ff[2])
                prog_q_ff <= prog_s_ff[2];
            if (pin_s_ff[1] == pin_s_ff[2])
                pin_q_ff <= pin_s_ff[2];
        end
    end

    // decoder only listens while a frame is expected
    mpl_man_rx u_rx (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .en_i(state_ff == ST_RX),
        .line_i(pin_q_ff),
        .bit_vld_o(rx_vld),
        .bit_o(rx_bit),
        .err_o(rx_err),
        .period_o(rx_period)
    );

    // acknowledge goes out at the rate the controller used
    mpl_man_tx u_tx (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .start_i(tx_start_ff),
        .word_i(ack_word_ff),
        .half_i(half_ff),
        .line_o(tx_line),
        .done_o(tx_done)
    );

    // frame field views; the first received bit is the direction
    // the oldest bit sits at nbit_ff - 1; with no bit in yet there is no direction
    assign is_write = (sr_ff[nbit_ff - 6'd1] == DIR_WRITE);
    assign frame_full = rx_vld && (nbit_ff != '0) && (nbit_ff == (sr_ff[nbit_ff - 6'd1] == DIR_WRITE ?
                        6'(WR_LEN - 1) : 6'(RD_LEN - 1)));
    assign f_addr = is_write ? sr_ff[CRC_W+DATA_W +: ADDR_W] : sr_ff[CRC_W +: ADDR_W];
    assign f_data = sr_ff[CRC_W +: DATA_W];
    assign crc_ok = (crc_ff == '0);
    assign ecc_code = (mem_rdata_i[DATA_W-1 -: ECC_W] ==
                       mpl_ecc_bits(mem_rdata_i[PAYLOAD_W-1:0])) ? ECC_PASS : ECC_FAIL;

    // shift in bits msb first, crc runs over everything after sync
    always_ff @(posedge clk_i)
    begin
        if (srst_i || state_ff != ST_RX)
        begin
            sr_ff <= '0;
            nbit_ff <= '0;
            crc_ff <= '0;
        end
        else if (rx_vld)
        begin
            sr_ff <= {sr_ff[WR_LEN-2:0], rx_bit}; // RULE6
            nbit_ff <= nbit_ff + 1'b1;
            crc_ff <= mpl_crc_step(crc_ff, rx_bit); // RULE18
        end
    end

    // access window counts from reset and never restarts before power cycle
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            acc_cnt_ff <= '0;
            acc_expired_ff <= 1'b0;
        end
        else if (!acc_expired_ff)
        begin
            acc_cnt_ff <= acc_cnt_ff + 1'b1;
            if (acc_cnt_ff == CNT_W'(ACCESS_TIMEOUT_CYC_P - 1))
                acc_expired_ff <= 1'b1; // RULE20
        end
    end

    // command state; a drop of program enable aborts anything in flight
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_ff <= ST_NORMAL;
            unlocked_o <= 1'b0;
            mem_wr_o <= 1'b0;
            mem_rd_o <= 1'b0;
            mem_vol_o <= 1'b0;
            mem_addr_o <= '0;
            mem_wdata_o <= '0;
            tx_start_ff <= 1'b0;
            ack_word_ff <= '0;
            half_ff <= '0;
            tmr_ff <= '0;
        end
        else
        begin
            mem_wr_o <= 1'b0;
            mem_rd_o <= 1'b0;
            tx_start_ff <= 1'b0;
            if (!prog_q_ff)
                state_ff <= ST_NORMAL; // RULE10
            else
            begin
                unique case (state_ff)
                    ST_NORMAL: state_ff <= ST_RX; // RULE1
                    ST_RX:
                    begin
                        if (rx_err)
                            state_ff <= ST_HOLD;
                        else if (frame_full)
                            state_ff <= ST_EXEC;
                    end
                    ST_EXEC:
                    begin
                        tmr_ff <= '0;
                        half_ff <= rx_period >> 1;
                        mem_addr_o <= f_addr; // RULE15
                        mem_vol_o <= f_addr[SPACE_BIT] != SPACE_EEPROM; // RULE21
                        state_ff <= ST_HOLD;
                        if (!crc_ok)
                            state_ff <= ST_HOLD; // RULE23
                        else if (is_write && f_addr == ACCESS_ADDR) // RULE7
                        begin
                            if (f_data == ACCESS_CODE && !acc_expired_ff)
                                unlocked_o <= 1'b1; // RULE20
                        end
                        else if (is_write && unlocked_o) // RULE14
                        begin
                            mem_wr_o <= 1'b1; // RULE2
                            mem_wdata_o <= {mpl_ecc_bits(f_data[PAYLOAD_W-1:0]),
                                            f_data[PAYLOAD_W-1:0]}; // RULE16 RULE22
                            if (f_addr[SPACE_BIT] == SPACE_EEPROM)
                                state_ff <= ST_EEWAIT; // RULE11
                        end
                        else if (!is_write && unlocked_o)
                        begin
                            mem_rd_o <= 1'b1;
                            state_ff <= ST_RDWAIT; // RULE3
                        end
                    end
                    ST_RDWAIT:
                    begin
                        ack_word_ff <= {{SYNC_W{1'b0}}, ACK_FILL, ecc_code,
                                        mem_rdata_i[PAYLOAD_W-1:0]}; // RULE17 RULE13
                        tx_start_ff <= 1'b1;
                        state_ff <= ST_TX; // RULE3
                    end
                    ST_TX:
                    begin
                        if (tx_done)
                            state_ff <= ST_HOLD; // RULE4
                    end
                    ST_EEWAIT:
                    begin
                        tmr_ff <= tmr_ff + 1'b1;
                        if (tmr_ff == CNT_W'(EE_WRITE_CYC_P - 1))
                            state_ff <= ST_HOLD; // RULE11
                    end
                    ST_HOLD: state_ff <= ST_HOLD; // RULE12
                    default: state_ff <= ST_HOLD;
                endcase
            end
        end
    end

    // pin released in programming except for acknowledge and write-done level
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !prog_q_ff)
        begin
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0; // RULE8
        end
        else if (state_ff == ST_TX)
        begin
            pin_o <= tx_line;
            pin_oe_o <= 1'b1;
        end
        else if (state_ff == ST_EEWAIT)
        begin
            pin_o <= 1'b1; // held high so the completion edge is visible
            pin_oe_o <= 1'b1;
        end
        // low level shown one cycle, then the pin is an input again
        else if (state_ff == ST_HOLD && pin_oe_o && pin_o)
            pin_o <= 1'b0; // RULE11
        else
            pin_oe_o <= 1'b0; // RULE8
    end

    // analog output comes back only after the re-enable delay
    always_ff @(posedge clk_i)
    begin
        if (srst_i || prog_q_ff)
        begin
            re_cnt_ff <= '0;
            sense_en_o <= 1'b0; // RULE8
        end
        else if (re_cnt_ff == CNT_W'(REENABLE_CYC_P - 1))
            sense_en_o <= 1'b1; // RULE10
        else
            re_cnt_ff <= re_cnt_ff + 1'b1;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    a_no_self_start: assert property ((state_ff == ST_NORMAL) |-> !tx_start_ff && !pin_oe_o) // RULE1
        else $error("device drove the link outside a command");
    a_write_no_ack: assert property (mem_wr_o |-> ##1 (state_ff != ST_TX)[*4]) // RULE2
        else $error("acknowledge started after a write");
    a_read_ack: assert property ((state_ff == ST_RDWAIT && prog_q_ff) |=> tx_start_ff ##1
                                 pin_oe_o) // RULE3
        else $error("read not followed by acknowledge");
    a_prog_release: assert property ($rose(prog_q_ff) |=> !sense_en_o ##1 !pin_oe_o) // RULE8
        else $error("pin still driven in programming");
    a_reenable_wait: assert property ($rose(sense_en_o) |->
                                      $past(re_cnt_ff) == CNT_W'(REENABLE_CYC_P - 1)) // RULE10
        else $error("output re-enabled early");
    a_ee_done_edge: assert property ((state_ff == ST_EEWAIT && prog_q_ff &&
                                      tmr_ff == CNT_W'(EE_WRITE_CYC_P - 1)) |=>
                                     pin_o ##1 (pin_oe_o && !pin_o)) // RULE11
        else $error("no falling edge after eeprom write");
    a_hold_ignore: assert property ((state_ff == ST_HOLD && prog_q_ff) |=>
                                    state_ff == ST_HOLD) // RULE12
        else $error("frame accepted without enable toggle");
    a_bad_crc_drop: assert property ((state_ff == ST_EXEC && !crc_ok) |=>
                                     !mem_wr_o && !mem_rd_o && $stable(unlocked_o)) // RULE23
        else $error("frame with bad check acted upon");
    a_locked_quiet: assert property (!unlocked_o |-> !mem_wr_o && !mem_rd_o) // RULE20
        else $error("memory access while locked");
    a_ecc_on_write: assert property (mem_wr_o |-> mem_wdata_o[DATA_W-1 -: ECC_W] ==
                                     mpl_ecc_bits(mem_wdata_o[PAYLOAD_W-1:0])) // RULE22
        else $error("stored check bits wrong");
    a_space_select: assert property ((mem_wr_o || mem_rd_o) |->
                                     mem_vol_o == mem_addr_o[SPACE_BIT]) // RULE21
        else $error("space select disagrees with address");

    c_unlock: cover property ($rose(unlocked_o));
    c_read_ack: cover property (state_ff == ST_TX ##1 state_ff == ST_HOLD);
    c_ee_write: cover property (state_ff == ST_EEWAIT ##1 state_ff == ST_HOLD);
endmodule
`default_nettype wire

// >>> tb/mpl_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module mpl_ctrl_model (
    input wire logic clk_i, // bench clock
    input wire logic line_i, // resolved pin level
    input wire logic dev_oe_i, // device drives pin
    output logic prog_en_o, // supply at program level
    output logic drv_o, // our drive level
    output logic oe_o // we drive the pin
);
    // idle: enable low, pin left to the pull-down
    initial
    begin
        prog_en_o = 1'b0;
        drv_o = 1'b0;
        oe_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // pin pulled low at once so start-up noise is no bit
    task automatic open_link();
        tick(1);
        prog_en_o = 1'b1;
        oe_o = 1'b1;
        drv_o = 1'b0;
        tick(40);
    endtask
    task automatic close_link();
        tick(1);
        oe_o = 1'b0;
        prog_en_o = 1'b0;
        tick(40);
    endtask
    // first half carries the bit, so 0 rises mid-bit and 1 falls
    task automatic send_bit(input logic b, input int h);
        drv_o = b;
        tick(h);
        drv_o = ~b;
        tick(h);
    endtask
    // last bit cut after its mid edge so device timing is not hidden
    task automatic send(input logic [36:0] m, input int n, input int h, input logic bad);
        logic [2:0] c;
        c = 3'h0;
        for (int i = n - 1; i >= 0; i--)
            c = {c[1:0], 1'b0} ^ ((c[2] ^ m[i]) ? 3'h3 : 3'h0);
        if (bad)
            c = ~c;
        oe_o = 1'b1;
        send_bit(1'b0, h);
        send_bit(1'b0, h);
        for (int i = n - 1; i >= 0; i--)
            send_bit(m[i], h);
        send_bit(c[2], h);
        send_bit(c[1], h);
        drv_o = c[0];
        tick(h);
        drv_o = ~c[0];
        tick(2);
        oe_o = 1'b0;
    endtask
    // sample each first half at its middle; no answer leaves ok low
    task automatic recv(input int h, output logic [31:0] w, output logic ok);
        int n;
        n = 0;
        w = '0;
        while (dev_oe_i !== 1'b1 && n < 2000)
        begin
            tick(1);
            n++;
        end
        ok = (n < 2000);
        if (ok)
        begin
            tick(h / 2);
            for (int i = 31; i >= 0; i--)
            begin
                w[i] = line_i;
                tick(2 * h);
            end
        end
    endtask
endmodule
`default_nettype wire

// >>> tb/mpl_link_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mpl_link_top_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic prog_en, c_drv, c_oe, pin_o, pin_oe, sense_en, unlocked;
    logic mem_wr, mem_rd, mem_vol;
    logic [5:0] mem_addr;
    logic [29:0] mem_wdata;
    logic [29:0] store = '0;
    wire logic [29:0] mem_rdata = mem_rd ? store : 30'h0;
    logic line;
    logic ok;
    logic [31:0] w;
    int wr_cnt = 0;
    int errors = 0;
    int cmp_count = 0;
    always #12.5 clk = ~clk;
    // pull-down when nobody drives the pin
    assign line = pin_oe ? pin_o : (c_oe ? c_drv : 1'b0);
    // external store; read data stands while the read strobe is high
    always @(posedge clk)
    begin
        if (mem_wr)
        begin
            store <= mem_wdata;
            wr_cnt <= wr_cnt + 1;
        end
    end
    mpl_link_top #(.EE_WRITE_CYC_P(50), .ACCESS_TIMEOUT_CYC_P(30000), .REENABLE_CYC_P(20))
    mpl_link_top_inst (.clk_i(clk), .srst_i(srst), .prog_en_i(prog_en), .pin_i(line),
        .pin_o(pin_o), .pin_oe_o(pin_oe), .sense_en_o(sense_en), .unlocked_o(unlocked),
        .mem_wr_o(mem_wr), .mem_rd_o(mem_rd), .mem_vol_o(mem_vol), .mem_addr_o(mem_addr),
        .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata));
    mpl_ctrl_model mpl_ctrl_model_inst (.clk_i(clk), .line_i(line), .dev_oe_i(pin_oe),
        .prog_en_o(prog_en), .drv_o(c_drv), .oe_o(c_oe));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic t_access();
        repeat (100) @(negedge clk);
        chk("oe_idle", 0, pin_oe);
        chk("sense_idle", 1, sense_en);
        chk("lock", 0, unlocked);
        mpl_ctrl_model_inst.open_link();
        chk("oe_prog", 0, pin_oe);
        mpl_ctrl_model_inst.send({1'b0, 6'h24, 30'h2C41_3737}, 37, 200, 1'b0);
        mpl_ctrl_model_inst.close_link();
        chk("unlock", 1, unlocked);
        $display("access done");
    endtask
    // slower rate: bit time learned from the sync edges
    task automatic t_wr_vol();
        int n0;
        n0 = wr_cnt;
        mpl_ctrl_model_inst.open_link();
        mpl_ctrl_model_inst.send({1'b0, 6'h21, 30'h3F12_3456}, 37, 300, 1'b0);
        repeat (30) @(negedge clk);
        chk("oe_wr", 0, pin_oe);
        mpl_ctrl_model_inst.close_link();
        chk("wr_cnt", 1, wr_cnt - n0);
        chk("vol", 1, mem_vol);
        chk("addr", 6'h21, mem_addr);
        chk("payload", 24'h12_3456, mem_wdata[23:0]);
        $display("write volatile done");
    endtask
    task automatic t_read();
        mpl_ctrl_model_inst.open_link();
        mpl_ctrl_model_inst.send({30'h0, 1'b1, 6'h21}, 7, 200, 1'b0);
        mpl_ctrl_model_inst.recv(200, w, ok);
        chk("ack", 1, ok);
        chk("ack_word", {8'h00, 24'h12_3456}, w);
        repeat (20) @(negedge clk);
        mpl_ctrl_model_inst.send({30'h0, 1'b1, 6'h21}, 7, 200, 1'b0);
        mpl_ctrl_model_inst.recv(200, w, ok);
        chk("second", 0, ok);
        mpl_ctrl_model_inst.close_link();
        mpl_ctrl_model_inst.open_link();
        mpl_ctrl_model_inst.send({30'h0, 1'b1, 6'h21}, 7, 200, 1'b1);
        mpl_ctrl_model_inst.recv(200, w, ok);
        chk("bad_crc", 0, ok);
        mpl_ctrl_model_inst.close_link();
        $display("read done");
    endtask
    task automatic t_ee();
        int n;
        n = 0;
        mpl_ctrl_model_inst.open_link();
        mpl_ctrl_model_inst.send({1'b0, 6'h05, 30'h00AB_CDEF}, 37, 200, 1'b0);
        for (int i = 0; i < 300 && !(pin_oe === 1'b1 && pin_o === 1'b0 && n > 0); i++)
        begin
            if (pin_oe === 1'b1 && pin_o === 1'b1)
                n++;
            @(negedge clk);
        end
        chk("ee_busy", 1, n >= 48 && n <= 53);
        chk("ee_end", 0, pin_o);
        chk("ee_space", 0, mem_vol);
        mpl_ctrl_model_inst.close_link();
        chk("oe_off", 0, pin_oe);
        chk("sense_on", 1, sense_en);
        $display("eeprom write done");
    endtask
    // watchdog a tenth past the expected run of about 90k cycles
    initial
    begin
        #2_500_000;
        errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (10) @(negedge clk);
        srst = 1'b0;
        t_access();
        t_wr_vol();
        t_read();
        t_ee();
        report_and_stop();
    end
endmodule
`default_nettype wire
